// [logic/scif_pkg.sv]
// constants, types and carriers of the smart card interface control block
// Contract
// [R1] supply target decoded from two select inputs
// [R2] activation starts on command falling edge, card present
// [R3] command high: supply pulled low, regulator off
// [R4] host reset forwarded to card reset output
// [R5] host undervoltage disables every card side pin
// [R6] card presence drives interrupt output low
// [R7] supply overload also drives interrupt low
// [R8] serial line passed both ways, idles released
// [R9] aux line C4 passed both ways, idles released
// [R10] aux line C8 passed both ways, idles released
// [R11] clock ratio chosen by two select inputs
// [R12] host supplies external reference clock input
// [R13] unit deselected: controls latched, host lines released
// [R14] insertion debounced about 8 ms before present
// [R15] card clock derived from external clock divider
// [R16] ratios 1/1, 1/2, 1/4, 1/8 supported
// [R17] fixed select order: 00,01,10,11 give 1,2,4,8
// [R18] host drives its lines open drain only
`default_nettype none
package scif_pkg;
	localparam int CLK_HZ = 125_000_000;
	localparam int DEBOUNCE_MS = 8;
	localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
	localparam int DEB_W = 20;
	localparam logic [1:0] IO_HOLD = 2'h3;
	localparam int NLINES = 3;
	localparam int LINE_SER = 0;
	localparam int LINE_AUX_A = 1;
	localparam int LINE_AUX_B = 2;
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_CLEAR = 4'h4;
	localparam logic [3:0] REG_ENABLE = 4'h8;
	localparam logic [3:0] REG_PINSTAT = 4'hC;
	localparam int NEVT = 4;
	localparam int EVT_INS = 0;
	localparam int EVT_REM = 1;
	localparam int EVT_OVL = 2;
	localparam int EVT_UV = 3;
	localparam logic [NEVT-1:0] ENABLE_RST = 4'hF;

	typedef enum logic [1:0] {SUP_3V0, SUP_5V0, SUP_1V8} scif_supply_t;
	typedef enum logic [1:0] {DIV_1, DIV_2, DIV_4, DIV_8} scif_ratio_t;
	typedef enum logic {ST_IDLE, ST_ACTIVE} scif_state_t;
	typedef enum logic [1:0] {OWN_NONE, OWN_HOST, OWN_CARD} scif_own_t;

	typedef struct packed {
		logic unit_sel_n;
		logic power_cmd_n;
		logic sel_lo;
		logic sel_hi;
		logic ratio_a;
		logic ratio_b;
		logic host_reset;
		logic detect_n;
		logic detect;
		logic overload;
		logic host_uv;
		logic ext_clk;
		logic [NLINES-1:0] host_line;
		logic [NLINES-1:0] card_line;
	} scif_pins_t;

	typedef struct packed {
		logic power_cmd_n;
		logic sel_lo;
		logic sel_hi;
		logic ratio_a;
		logic ratio_b;
		logic host_reset;
	} scif_ctl_t;

	typedef struct packed {
		scif_pins_t sync1;
		scif_pins_t sync2;
		logic ext_prev;
		scif_ctl_t ctl;
		logic cmd_prev;
		logic [DEB_W-1:0] deb_cnt;
		logic present;
		logic ovl_prev;
		logic uv_prev;
		scif_state_t st;
		scif_supply_t supply;
		logic supply_en;
		logic card_reset;
		scif_own_t [NLINES-1:0] own;
		logic [NLINES-1:0][1:0] hold;
		logic [NLINES-1:0] host_oe_n;
		logic [NLINES-1:0] card_oe_n;
		logic [NEVT-1:0] status;
		logic [NEVT-1:0] enable;
		logic [31:0] rdata;
	} scif_state_s_t;

	typedef struct packed {
		logic [2:0] cnt;
		logic clk_out;
	} scif_div_t;
endpackage
`default_nettype wire

// [logic/scif_clkdiv.sv]
// card clock divider stepped by edges of the sampled external clock
`timescale 1ns/1ps
`default_nettype none
module scif_clkdiv
	import scif_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// control
	input wire logic en_i,
	input wire logic ext_lvl_i,
	input wire logic ext_rise_i,
	input wire scif_ratio_t ratio_i,
	// card clock
	output logic card_clk_o
);
	scif_div_t q;
	scif_div_t d;

	always_comb
	begin
		d = q;
		if (!en_i)
		begin
			d.cnt = 3'h0;
			d.clk_out = 1'b0;
		end
		else
		begin
			if (ext_rise_i)
				d.cnt = q.cnt + 3'h1;
			case (ratio_i) // [R16] [R17]
				DIV_1: d.clk_out = ext_lvl_i;
				DIV_2: d.clk_out = d.cnt[0];
				DIV_4: d.clk_out = d.cnt[1];
				DIV_8: d.clk_out = d.cnt[2];
				default: d.clk_out = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			q <= '0;
		else
			q <= d;
	end

	assign card_clk_o = q.clk_out; // [R15]

	property p_div2_toggle;
		@(posedge clk_i) disable iff (!rstn_i)
		(en_i && $past(en_i) && ratio_i == DIV_2 && $past(ratio_i) == DIV_2 && ext_rise_i)
		|=> (card_clk_o != $past(card_clk_o));
	endproperty
	a_div2_toggle: assert property (p_div2_toggle) else $error("divide by two missed a toggle"); // [R11]

	property p_off_low;
		@(posedge clk_i) disable iff (!rstn_i)
		!en_i |=> !card_clk_o;
	endproperty
	a_off_low: assert property (p_off_low) else $error("card clock runs while disabled"); // [R15]
endmodule // scif_clkdiv
`default_nettype wire

// [logic/scif_top.sv]
// smart card interface control: activation, supply select, lines, clock, interrupt
`timescale 1ns/1ps
`default_nettype none
module scif_top
	import scif_pkg::*;
#(
	parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC
)
(
	// clock and reset
	input wire logic CLK_I,
	input wire logic RSTN_I,
	// host control pins
	input wire logic UNIT_SELECT_N_I,
	input wire logic POWER_COMMAND_N_I,
	input wire logic SUPPLY_SELECT_LO_I,
	input wire logic SUPPLY_SELECT_HI_I,
	input wire logic CLOCK_RATIO_SEL_A_I,
	input wire logic CLOCK_RATIO_SEL_B_I,
	input wire logic HOST_RESET_IN_I,
	input wire logic EXT_CLOCK_IN_I,
	// monitors and card detect
	input wire logic CARD_DETECT_N_I,
	input wire logic CARD_DETECT_I,
	input wire logic SUPPLY_OVERLOAD_I,
	input wire logic HOST_UNDERVOLT_I,
	// host side open drain lines: serial, aux a, aux b
	input wire logic [NLINES-1:0] HOST_LINE_I,
	output logic [NLINES-1:0] HOST_LINE_O,
	output logic [NLINES-1:0] HOST_LINE_OE_N_O,
	// card side open drain lines: card_io, card_aux_a, card_aux_b
	input wire logic [NLINES-1:0] CARD_LINE_I,
	output logic [NLINES-1:0] CARD_LINE_O,
	output logic [NLINES-1:0] CARD_LINE_OE_N_O,
	// card supply, reset, clock
	output logic [1:0] CARD_SUPPLY_SEL_O,
	output logic CARD_SUPPLY_EN_O,
	output logic CARD_SUPPLY_PULLDOWN_O,
	output logic CARD_RESET_OUT_O,
	output logic CARD_CLOCK_OUT_O,
	// interrupt
	output logic INT_N_O,
	// register port
	input wire logic [3:0] REG_ADDR_I,
	input wire logic [31:0] REG_WDATA_I,
	input wire logic REG_WE_I,
	input wire logic REG_RE_I,
	output logic [31:0] REG_RDATA_O
);
	localparam logic [DEB_W-1:0] DEB_LAST = DEB_W'(DEBOUNCE_CYCLES - 1);

	scif_state_s_t q;
	scif_state_s_t d;
	scif_pins_t pins;
	scif_pins_t s;
	logic raw_present;
	logic cmd_fall;
	logic uv;
	logic line_en;
	logic [NEVT-1:0] evt;

	always_comb
	begin
		pins.unit_sel_n = UNIT_SELECT_N_I;
		pins.power_cmd_n = POWER_COMMAND_N_I;
		pins.sel_lo = SUPPLY_SELECT_LO_I;
		pins.sel_hi = SUPPLY_SELECT_HI_I;
		pins.ratio_a = CLOCK_RATIO_SEL_A_I;
		pins.ratio_b = CLOCK_RATIO_SEL_B_I;
		pins.host_reset = HOST_RESET_IN_I;
		pins.detect_n = CARD_DETECT_N_I;
		pins.detect = CARD_DETECT_I;
		pins.overload = SUPPLY_OVERLOAD_I;
		pins.host_uv = HOST_UNDERVOLT_I;
		pins.ext_clk = EXT_CLOCK_IN_I;
		pins.host_line = HOST_LINE_I;
		pins.card_line = CARD_LINE_I;
	end

	assign s = q.sync2;
	assign uv = s.host_uv;
	assign raw_present = !s.detect_n || s.detect;
	assign cmd_fall = q.cmd_prev && !q.ctl.power_cmd_n;

	always_comb
	begin
		d = q;
		line_en = 1'b0;
		evt = '0;
		d.sync1 = pins;
		d.sync2 = q.sync1;
		d.ext_prev = s.ext_clk;

		// controls follow the pins only while the unit is selected
		if (!s.unit_sel_n) // [R13]
		begin
			d.ctl.power_cmd_n = s.power_cmd_n;
			d.ctl.sel_lo = s.sel_lo;
			d.ctl.sel_hi = s.sel_hi;
			d.ctl.ratio_a = s.ratio_a;
			d.ctl.ratio_b = s.ratio_b;
			d.ctl.host_reset = s.host_reset;
		end
		d.cmd_prev = q.ctl.power_cmd_n;

		// insertion waits for the debounce time, removal is immediate
		if (!raw_present)
		begin
			d.deb_cnt = '0;
			d.present = 1'b0;
		end
		else if (!q.present)
		begin
			if (q.deb_cnt == DEB_LAST) // [R14]
				d.present = 1'b1;
			else
				d.deb_cnt = q.deb_cnt + 1'b1;
		end

		if (q.ctl.sel_lo) // [R1]
			d.supply = q.ctl.sel_hi ? SUP_1V8 : SUP_3V0;
		else
			d.supply = q.ctl.sel_hi ? SUP_5V0 : SUP_3V0;

		case (q.st)
			ST_IDLE:
				if (cmd_fall && q.present && !uv && !s.overload) // [R2]
					d.st = ST_ACTIVE;
			ST_ACTIVE:
				if (q.ctl.power_cmd_n || !q.present || uv || s.overload) // [R3] [R5]
					d.st = ST_IDLE;
			default: d.st = ST_IDLE;
		endcase

		d.supply_en = (d.st == ST_ACTIVE); // [R3]
		d.card_reset = (d.st == ST_ACTIVE) && q.ctl.host_reset; // [R4]

		// lines pass only while active, selected and host supply good
		line_en = (q.st == ST_ACTIVE) && !uv && !s.unit_sel_n; // [R5] [R13]
		for (int i = 0; i < NLINES; i++) // [R8] [R9] [R10]
		begin
			if (!line_en)
			begin
				d.own[i] = OWN_NONE;
				d.hold[i] = 2'h0;
			end
			else
			begin
				case (q.own[i])
					OWN_NONE:
						if (q.hold[i] != 2'h0)
							d.hold[i] = q.hold[i] - 2'h1;
						else if (!s.host_line[i])
							d.own[i] = OWN_HOST;
						else if (!s.card_line[i])
							d.own[i] = OWN_CARD;
					OWN_HOST:
						if (s.host_line[i])
						begin
							d.own[i] = OWN_NONE;
							d.hold[i] = IO_HOLD;
						end
					OWN_CARD:
						if (s.card_line[i])
						begin
							d.own[i] = OWN_NONE;
							d.hold[i] = IO_HOLD;
						end
					default: d.own[i] = OWN_NONE;
				endcase
			end
			d.card_oe_n[i] = (d.own[i] != OWN_HOST);
			d.host_oe_n[i] = (d.own[i] != OWN_CARD);
		end

		// events, a new event wins over a clear in the same cycle
		d.ovl_prev = s.overload;
		d.uv_prev = uv;
		evt[EVT_INS] = d.present && !q.present; // [R6]
		evt[EVT_REM] = !d.present && q.present;
		evt[EVT_OVL] = s.overload && !q.ovl_prev; // [R7]
		evt[EVT_UV] = uv && !q.uv_prev;
		if (REG_WE_I && REG_ADDR_I == REG_CLEAR)
			d.status = q.status & ~REG_WDATA_I[NEVT-1:0];
		d.status = d.status | evt;
		if (REG_WE_I && REG_ADDR_I == REG_ENABLE)
			d.enable = REG_WDATA_I[NEVT-1:0];

		d.rdata = 32'h0000_0000;
		if (REG_RE_I)
		begin
			case (REG_ADDR_I)
				REG_STATUS: d.rdata = {28'h0, q.status};
				REG_ENABLE: d.rdata = {28'h0, q.enable};
				REG_PINSTAT: d.rdata = {24'h0, s.overload, uv, q.ctl.ratio_b,
					q.ctl.ratio_a, q.supply, (q.st == ST_ACTIVE), q.present};
				default: d.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			q <= '0;
			// command and detect synchronisers start at idle pin levels: no false command edge or detect
			q.sync1.power_cmd_n <= 1'b1;
			q.sync2.power_cmd_n <= 1'b1;
			q.sync1.detect_n <= 1'b1;
			q.sync2.detect_n <= 1'b1;
			q.ctl.power_cmd_n <= 1'b1;
			q.cmd_prev <= 1'b1;
			q.host_oe_n <= '1;
			q.card_oe_n <= '1;
			q.enable <= ENABLE_RST;
		end
		else
			q <= d;
	end

	scif_clkdiv u_clkdiv (
		.clk_i(CLK_I),
		.rstn_i(RSTN_I),
		.en_i(q.st == ST_ACTIVE && !uv),
		.ext_lvl_i(s.ext_clk),
		.ext_rise_i(s.ext_clk && !q.ext_prev),
		.ratio_i(scif_ratio_t'({q.ctl.ratio_b, q.ctl.ratio_a})), // [R11]
		.card_clk_o(CARD_CLOCK_OUT_O)
	);

	assign HOST_LINE_O = '0;
	assign HOST_LINE_OE_N_O = q.host_oe_n;
	assign CARD_LINE_O = '0;
	assign CARD_LINE_OE_N_O = q.card_oe_n;
	assign CARD_SUPPLY_SEL_O = q.supply;
	assign CARD_SUPPLY_EN_O = q.supply_en;
	assign CARD_SUPPLY_PULLDOWN_O = !q.supply_en;
	assign CARD_RESET_OUT_O = q.card_reset;
	assign INT_N_O = !(|(q.status & q.enable)); // [R6] [R7]
	assign REG_RDATA_O = q.rdata;

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);

	property p_supply_18;
		q.ctl.sel_lo && q.ctl.sel_hi |=> CARD_SUPPLY_SEL_O == SUP_1V8;
	endproperty
	a_supply_18: assert property (p_supply_18) else $error("1.8 V not selected"); // [R1]

	property p_supply_50;
		!q.ctl.sel_lo && q.ctl.sel_hi |=> CARD_SUPPLY_SEL_O == SUP_5V0;
	endproperty
	a_supply_50: assert property (p_supply_50) else $error("5 V not selected"); // [R1]

	property p_act_start;
		q.st == ST_IDLE && cmd_fall && q.present && !uv && !s.overload
		|=> CARD_SUPPLY_EN_O ##0 q.st == ST_ACTIVE;
	endproperty
	a_act_start: assert property (p_act_start) else $error("activation did not start"); // [R2]

	property p_cmd_off;
		q.ctl.power_cmd_n |=> !CARD_SUPPLY_EN_O && CARD_SUPPLY_PULLDOWN_O;
	endproperty
	a_cmd_off: assert property (p_cmd_off) else $error("supply on with command high"); // [R3]

	property p_reset_fwd;
		q.st == ST_ACTIVE && !q.ctl.power_cmd_n && q.present && !uv && !s.overload
		|=> CARD_RESET_OUT_O == $past(q.ctl.host_reset);
	endproperty
	a_reset_fwd: assert property (p_reset_fwd) else $error("card reset not forwarded"); // [R4]

	property p_uv_off;
		uv |=> (CARD_LINE_OE_N_O == '1 && !CARD_SUPPLY_EN_O && !CARD_RESET_OUT_O
			&& !CARD_CLOCK_OUT_O);
	endproperty
	a_uv_off: assert property (p_uv_off) else $error("card pins live under undervoltage"); // [R5]

	property p_int_ins;
		$rose(q.present) && q.enable[EVT_INS] |-> !INT_N_O;
	endproperty
	a_int_ins: assert property (p_int_ins) else $error("no interrupt on card presence"); // [R6]

	property p_int_ovl;
		s.overload && !q.ovl_prev && q.enable[EVT_OVL]
			&& !(REG_WE_I && REG_ADDR_I == REG_ENABLE) |=> !INT_N_O;
	endproperty
	a_int_ovl: assert property (p_int_ovl) else $error("no interrupt on overload"); // [R7]

	property p_ser_drive;
		q.own[LINE_SER] == OWN_HOST |-> !CARD_LINE_OE_N_O[LINE_SER] && HOST_LINE_OE_N_O[LINE_SER];
	endproperty
	a_ser_drive: assert property (p_ser_drive) else $error("serial line not passed to card"); // [R8]

	property p_aux_a_drive;
		q.own[LINE_AUX_A] == OWN_CARD |-> !HOST_LINE_OE_N_O[LINE_AUX_A];
	endproperty
	a_aux_a_drive: assert property (p_aux_a_drive) else $error("aux a not passed to host"); // [R9]

	property p_aux_b_idle;
		q.own[LINE_AUX_B] == OWN_NONE |-> HOST_LINE_OE_N_O[LINE_AUX_B]
			&& CARD_LINE_OE_N_O[LINE_AUX_B];
	endproperty
	a_aux_b_idle: assert property (p_aux_b_idle) else $error("aux b driven while idle"); // [R10]

	property p_desel_hiz;
		s.unit_sel_n |=> HOST_LINE_OE_N_O == '1 ##0 $stable(q.ctl);
	endproperty
	a_desel_hiz: assert property (p_desel_hiz) else $error("deselect did not latch"); // [R13]

	property p_debounce;
		$rose(q.present) |-> $past(q.deb_cnt) == DEB_LAST;
	endproperty
	a_debounce: assert property (p_debounce) else $error("presence before debounce end"); // [R14]

	c_activate: cover property (cmd_fall && q.present ##1 q.st == ST_ACTIVE);
	c_overload: cover property (q.st == ST_ACTIVE ##1 s.overload ##1 !INT_N_O);
	c_host_drv: cover property (q.own[LINE_SER] == OWN_HOST ##1 q.own[LINE_SER] == OWN_NONE);
endmodule // scif_top
`default_nettype wire

// [bench/scif_card_model.sv]
// card side of the three open drain lines, pulled up to the card supply
`timescale 1ns/1ps
`default_nettype none
module scif_card_model
(
	// device drive and card drive
	input wire logic [2:0] dev_oe_n_i,
	input wire logic [2:0] card_pull_i,
	// resolved line levels
	output logic [2:0] line_o
);
	// released lines read high; any party pulling low wins
	assign line_o = dev_oe_n_i & ~card_pull_i;
endmodule // scif_card_model
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench of the smart card interface control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int DEB = 16;
	logic clk = 1'b0;
	logic rstn, usel_n, cmd_n, sel_lo, sel_hi, rat_a, rat_b, hrst, ext, det_n, det, ovl, uv;
	logic we, re, sup_en, sup_pd, card_reset_out, card_clock_out, int_n;
	logic [3:0] addr;
	logic [31:0] wdata, rdata, rv;
	logic [2:0] host_pull, card_pull, hl_i, hl_o, hl_oe_n, cl_i, cl_o, cl_oe_n, ec;
	logic [1:0] sup_sel;
	int miscompares = 0;
	int checks = 0;

	always #4 clk = ~clk;
	// external reference clock, one rise every eight cycles
	always @(posedge clk)
	begin
		ec <= rstn ? ec + 3'h1 : 3'h0;
		ext <= rstn & ec[2];
	end
	assign hl_i = hl_oe_n & ~host_pull;

	scif_card_model i_card (.dev_oe_n_i(cl_oe_n), .card_pull_i(card_pull), .line_o(cl_i));

	scif_top #(.DEBOUNCE_CYCLES(DEB)) i_dut (.CLK_I(clk), .RSTN_I(rstn),
		.UNIT_SELECT_N_I(usel_n), .POWER_COMMAND_N_I(cmd_n), .SUPPLY_SELECT_LO_I(sel_lo),
		.SUPPLY_SELECT_HI_I(sel_hi), .CLOCK_RATIO_SEL_A_I(rat_a), .CLOCK_RATIO_SEL_B_I(rat_b),
		.HOST_RESET_IN_I(hrst), .EXT_CLOCK_IN_I(ext), .CARD_DETECT_N_I(det_n),
		.CARD_DETECT_I(det), .SUPPLY_OVERLOAD_I(ovl), .HOST_UNDERVOLT_I(uv),
		.HOST_LINE_I(hl_i), .HOST_LINE_O(hl_o), .HOST_LINE_OE_N_O(hl_oe_n),
		.CARD_LINE_I(cl_i), .CARD_LINE_O(cl_o), .CARD_LINE_OE_N_O(cl_oe_n),
		.CARD_SUPPLY_SEL_O(sup_sel), .CARD_SUPPLY_EN_O(sup_en),
		.CARD_SUPPLY_PULLDOWN_O(sup_pd), .CARD_RESET_OUT_O(card_reset_out), .CARD_CLOCK_OUT_O(card_clock_out),
		.INT_N_O(int_n), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WE_I(we),
		.REG_RE_I(re), .REG_RDATA_O(rdata));

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// outputs are read at the edge, before that edge's updates land
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		we <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		we <= 1'b0;
	endtask

	// read data stand for one cycle only, so they are taken at the falling edge
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		re <= 1'b1;
		addr <= a;
		@(posedge clk);
		re <= 1'b0;
		@(negedge clk);
		rv = rdata;
		@(posedge clk);
	endtask

	task automatic t_reset;
		check(int_n, 1'b1);
		check({sup_en, sup_pd, card_reset_out, card_clock_out}, 4'h4);
		check({hl_oe_n, cl_oe_n}, 6'h3F);
		rd(scif_pkg::REG_ENABLE);
		check(rv, 32'hF);
		rd(4'h2);
		check(rv, 32'h0);
		$display("reset test done");
	endtask

	task automatic t_presence;
		cmd_n <= 1'b0;
		cyc(8);
		check(sup_en, 1'b0);
		cmd_n <= 1'b1;
		for (int k = 0; k < 2; k++)
		begin
			if (k == 0)
				det_n <= 1'b0;
			else
				det <= 1'b1;
			// two synchroniser cycles, then the debounce count
			cyc(DEB + 1);
			check(int_n, 1'b1);
			cyc(2);
			check(int_n, 1'b0);
			rd(scif_pkg::REG_STATUS);
			check(rv, 32'h1);
			wr(scif_pkg::REG_ENABLE, 32'h0);
			cyc(2);
			check(int_n, 1'b1);
			wr(scif_pkg::REG_ENABLE, 32'hF);
			wr(scif_pkg::REG_CLEAR, 32'hF);
			cyc(2);
			check(int_n, 1'b1);
			if (k == 0)
			begin
				det_n <= 1'b1;
				cyc(6);
				check(int_n, 1'b0);
				wr(scif_pkg::REG_CLEAR, 32'hF);
			end
		end
		$display("presence test done");
	endtask

	task automatic t_supply;
		logic [1:0] code;
		for (int v = 0; v < 4; v++)
		begin
			sel_lo <= v[0];
			sel_hi <= v[1];
			code = !v[1] ? scif_pkg::SUP_3V0 : v[0] ? scif_pkg::SUP_1V8 : scif_pkg::SUP_5V0;
			cyc(4);
			cmd_n <= 1'b0;
			cyc(8);
			check({sup_en, sup_pd}, 2'h2);
			check(sup_sel, code);
			rd(scif_pkg::REG_PINSTAT);
			check(rv, {28'h0000000, code, 2'h3});
			hrst <= 1'b1;
			cyc(6);
			check(card_reset_out, 1'b1);
			hrst <= 1'b0;
			cyc(6);
			check(card_reset_out, 1'b0);
			cmd_n <= 1'b1;
			cyc(8);
			check({sup_en, sup_pd}, 2'h1);
		end
		$display("supply test done");
	endtask

	task automatic t_clock;
		int n;
		logic p;
		cmd_n <= 1'b0;
		cyc(8);
		for (int r = 0; r < 4; r++)
		begin
			rat_a <= r[0];
			rat_b <= r[1];
			cyc(24);
			n = 0;
			p = card_clock_out;
			repeat (256)
			begin
				@(posedge clk);
				if (card_clock_out && !p)
					n++;
				p = card_clock_out;
			end
			// 32 reference rises in the window, divided by 1, 2, 4, 8
			check(n >= (32 >> r) - 1 && n <= (32 >> r) + 1, 1'b1);
		end
		$display("clock test done");
	endtask

	task automatic t_lines;
		logic [2:0] m;
		for (int i = 0; i < 3; i++)
		begin
			m = ~(3'h1 << i);
			host_pull[i] <= 1'b1;
			cyc(6);
			check(cl_oe_n, m);
			host_pull[i] <= 1'b0;
			cyc(8);
			check(cl_oe_n, 3'h7);
			card_pull[i] <= 1'b1;
			cyc(6);
			check(hl_oe_n, m);
			card_pull[i] <= 1'b0;
			cyc(8);
			check(hl_oe_n, 3'h7);
		end
		check({hl_o, cl_o}, 6'h0);
		$display("line test done");
	endtask

	task automatic t_deselect;
		usel_n <= 1'b1;
		cyc(6);
		host_pull <= 3'h7;
		card_pull <= 3'h7;
		sel_hi <= 1'b0;
		cmd_n <= 1'b1;
		cyc(8);
		check(cl_oe_n, 3'h7);
		check(hl_oe_n, 3'h7);
		check(sup_sel, scif_pkg::SUP_1V8);
		check(sup_en, 1'b1);
		host_pull <= 3'h0;
		card_pull <= 3'h0;
		usel_n <= 1'b0;
		cyc(8);
		check(sup_en, 1'b0);
		$display("deselect test done");
	endtask

	task automatic t_faults;
		cmd_n <= 1'b0;
		cyc(8);
		ovl <= 1'b1;
		cyc(6);
		check({int_n, sup_en}, 2'h0);
		rd(scif_pkg::REG_STATUS);
		check(rv, 32'h4);
		ovl <= 1'b0;
		wr(scif_pkg::REG_CLEAR, 32'hF);
		cmd_n <= 1'b1;
		cyc(4);
		cmd_n <= 1'b0;
		hrst <= 1'b1;
		cyc(8);
		check({sup_en, card_reset_out}, 2'h3);
		host_pull[0] <= 1'b1;
		cyc(6);
		check(cl_oe_n, 3'h6);
		uv <= 1'b1;
		cyc(6);
		check({sup_en, card_clock_out, card_reset_out}, 3'h0);
		check(cl_oe_n, 3'h7);
		rd(scif_pkg::REG_STATUS);
		check(rv, 32'h8);
		uv <= 1'b0;
		hrst <= 1'b0;
		host_pull[0] <= 1'b0;
		$display("fault test done");
	endtask

	task automatic finish_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial
	begin
		{rstn, usel_n, sel_lo, sel_hi, rat_a, rat_b, hrst, det, ovl, uv, we, re} = 12'h0;
		{cmd_n, det_n} = 2'h3;
		{addr, wdata, host_pull, card_pull} = 42'h0;
		cyc(12);
		rstn <= 1'b1;
		cyc(2);
		t_reset;
		t_presence;
		t_supply;
		t_clock;
		t_lines;
		t_deselect;
		t_faults;
		finish_test;
	end

	// run needs about 1500 cycles
	initial
	begin
		#(8 * 20000);
		miscompares++;
		finish_test;
	end
endmodule // testbench
`default_nettype wire
